/* File: hdl/awitr_pkg.sv */
`default_nettype none
package awitr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // Register byte addresses, one aligned word each.
    localparam logic [7:0] OFS_OFFSET_CAL = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h08;
    localparam logic [7:0] OFS_ANALOG_SEL = 8'h0c;
    localparam logic [7:0] OFS_WAKE_CTRL = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_DIR5 = 8'h1c;
    localparam logic [7:0] OFS_DIR6 = 8'h20;
    localparam logic [7:0] OFS_DIR7 = 8'h24;
    localparam logic [7:0] OFS_DIR8 = 8'h28;
    localparam logic [7:0] OFS_TIMER_CTRL = 8'h2c;
    localparam logic [7:0] OFS_CONV_CTRL = 8'h30;
    localparam logic [7:0] OFS_LVD_CTRL = 8'h34;
    // Field positions.
    localparam int unsigned CAL_EN_BIT = 7;
    localparam int unsigned CAL_SIGN_BIT = 6;
    localparam int unsigned CAL_MAG_LSB = 3;
    localparam int unsigned CAL_PWR_BIT = 2;
    localparam int unsigned CAL_LVL_LSB = 0;
    localparam int unsigned RLOW_PIN_LSB = 4;
    localparam int unsigned WAKE_FLAG_BIT = 6;
    localparam int unsigned WAKE_LVD_BIT = 5;
    localparam int unsigned WAKE_PC_BIT = 4;
    localparam int unsigned WAKE_CONV_BIT = 3;
    localparam int unsigned IRQ_EXT1 = 7;
    localparam int unsigned IRQ_PWM_C = 6;
    localparam int unsigned IRQ_PWM_B = 5;
    localparam int unsigned IRQ_PWM_A = 4;
    localparam int unsigned IRQ_CONV = 3;
    localparam int unsigned IRQ_EXT0 = 2;
    localparam int unsigned IRQ_PC = 1;
    localparam int unsigned IRQ_TICK = 0;
    localparam int unsigned TMR_C_ON_BIT = 7;
    localparam int unsigned TMR_B_ON_BIT = 6;
    localparam int unsigned TMR_C_PRE_LSB = 3;
    localparam int unsigned TMR_B_PRE_LSB = 0;
    localparam int unsigned CONV_RUN_BIT = 4;
    localparam int unsigned LVD_ON_BIT = 7;
    localparam int unsigned LVD_IE_BIT = 6;
    // Reset values.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [2:0] PIN_IDLE = 3'h7;

    typedef struct packed {
        logic conv_done;
        logic [11:0] conv_result;
        logic pwm_a_match;
        logic pwm_b_match;
        logic pwm_c_match;
        logic tick_overflow;
    } awitr_events_t;

    typedef struct packed {
        logic offset_cal_enable;
        logic offset_positive;
        logic [3:0] offset_lsb;
        logic converter_power;
        logic [1:0] lowvolt_level;
        logic [5:0] lowvolt_tenths;
        logic lowvolt_detector_on;
        logic conv_run;
        logic [3:0] conv_channel;
        logic [14:0] analog_en;
    } awitr_analog_cfg_t;

    typedef struct packed {
        logic timer_c_on;
        logic timer_b_on;
        logic [8:0] timer_c_ratio;
        logic [8:0] timer_b_ratio;
    } awitr_timer_cfg_t;

    typedef struct packed {
        logic [7:0] p5;
        logic [7:0] p6;
        logic [7:0] p7;
        logic p8;
    } awitr_port_dir_t;

    function automatic logic [8:0] prescale_ratio(input logic [2:0] code);
        logic [8:0] r;
        unique case (code)
            3'h0: r = 9'h001;
            3'h1: r = 9'h002;
            3'h2: r = 9'h004;
            3'h3: r = 9'h008;
            3'h4: r = 9'h010;
            3'h5: r = 9'h040;
            3'h6: r = 9'h080;
            3'h7: r = 9'h100;
        endcase
        return r;
    endfunction

    // Threshold in tenths of a volt.
    function automatic logic [5:0] lowvolt_tenths(input logic [1:0] code);
        logic [5:0] t;
        unique case (code)
            2'h3: t = 6'h16;
            2'h2: t = 6'h21;
            2'h1: t = 6'h28;
            2'h0: t = 6'h2d;
        endcase
        return t;
    endfunction
endpackage
`default_nettype wire

/* File: hdl/awitr_regs.sv */
// Notes on behaviour
// - Offset calibration enable is bit seven.
// - Sign bit picks negative or positive offset.
// - Offset magnitude equals twice the code.
// - Power bit zero switches reference off.
// - Level field picks detector threshold voltage.
// - Enabled detector crossing sets flag; else zero.
// - Completion loads high result, clears run.
// - Completion loads low nibble, keeps pin bits.
// - Low result top bits enable channels 8-11.
// - Select register enables port six analog.
// - Wake register low bits enable 12-14.
// - Low-voltage flag clears, never set by software.
// - Low-voltage wake needs its enable bit.
// - Pin-change wake needs its enable bit.
// - Conversion wake needs its enable bit.
// - Status holds eight flags, software clears only.
// - Status read returns flags AND mask.
// - Each flag set by its own event.
// - Direction one means input, zero output.
// - Timer enable bits, both reset off.
// - Prescale codes decode to eight ratios.
// - Software starts conversion; only completion clears.
// - Channel writes only while idle and clear.
// - Detector enable bit turns detector on.
//
// The APB slave port and the register offsets were decided locally.
`default_nettype none
module awitr_regs (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [awitr_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [awitr_pkg::DATA_W-1:0] pwdata_i,
    output logic [awitr_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire awitr_pkg::awitr_events_t events_i,
    input wire logic ext_irq_pin_0_i,
    input wire logic ext_irq_pin_1_i,
    input wire logic [7:0] port6_pin_i,
    input wire logic supply_below_i,
    output awitr_pkg::awitr_analog_cfg_t analog_cfg_o,
    output awitr_pkg::awitr_timer_cfg_t timer_cfg_o,
    output awitr_pkg::awitr_port_dir_t port_dir_o,
    output logic wake_request_o,
    output logic irq_request_o
);
    import awitr_pkg::*;

    typedef struct packed {
        logic [7:0] offset_cal;
        logic [7:0] result_high;
        logic [7:0] result_low;
        logic [7:0] analog_sel;
        logic [7:0] wake_ctrl;
        logic [7:0] irq_flags;
        logic [7:0] irq_mask;
        logic [7:0] dir5;
        logic [7:0] dir6;
        logic [7:0] dir7;
        logic dir8;
        logic [7:0] timer_ctrl;
        logic conv_run;
        logic [3:0] conv_chan;
        logic lvd_on;
        logic lvd_irq_en;
        logic [2:0] ext0_s;
        logic [2:0] ext1_s;
        logic [2:0] below_s;
        logic [7:0] p6_s1;
        logic [7:0] p6_s2;
        logic [7:0] p6_prev;
    } awitr_state_t;

    awitr_state_t st;
    awitr_state_t next_st;
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] wbyte;
    logic [7:0] ev;
    logic lvd_set;
    logic [31:0] rdata;

    // Event vector in status bit order; the pin samples are the second and third stages.
    always_comb begin
        ev = 8'h00;
        ev[IRQ_EXT1] = st.ext1_s[2] & ~st.ext1_s[1];
        ev[IRQ_PWM_C] = events_i.pwm_c_match;
        ev[IRQ_PWM_B] = events_i.pwm_b_match;
        ev[IRQ_PWM_A] = events_i.pwm_a_match;
        ev[IRQ_CONV] = events_i.conv_done;
        ev[IRQ_EXT0] = st.ext0_s[2] & ~st.ext0_s[1];
        ev[IRQ_PC] = |(st.p6_s2 ^ st.p6_prev);
        ev[IRQ_TICK] = events_i.tick_overflow;
    end

    assign lvd_set = st.lvd_on & st.below_s[1] & ~st.below_s[2];

    assign wr = psel_i & penable_i & pwrite_i;
    assign rd = psel_i & penable_i & ~pwrite_i;
    assign wbyte = pwdata_i[7:0];

    always_comb begin
        mapped = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr_i)
            OFS_OFFSET_CAL: rdata[7:0] = st.offset_cal;
            OFS_RESULT_HIGH: rdata[7:0] = st.result_high;
            OFS_RESULT_LOW: rdata[7:0] = st.result_low;
            OFS_ANALOG_SEL: rdata[7:0] = st.analog_sel;
            OFS_WAKE_CTRL: rdata[7:0] = {1'b0, st.wake_ctrl[WAKE_FLAG_BIT] & st.lvd_irq_en,
                                         st.wake_ctrl[5:0]};
            OFS_IRQ_STATUS: rdata[7:0] = st.irq_flags & st.irq_mask;
            OFS_IRQ_MASK: rdata[7:0] = st.irq_mask;
            OFS_DIR5: rdata[7:0] = st.dir5;
            OFS_DIR6: rdata[7:0] = st.dir6;
            OFS_DIR7: rdata[7:0] = st.dir7;
            OFS_DIR8: rdata[0] = st.dir8;
            OFS_TIMER_CTRL: rdata[7:0] = st.timer_ctrl;
            OFS_CONV_CTRL: rdata[4:0] = {st.conv_run, st.conv_chan};
            OFS_LVD_CTRL: rdata[7:6] = {st.lvd_on, st.lvd_irq_en};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        // Synchronisers: stage one feeds stage two only; stage three is the edge history.
        next_st.ext0_s = {st.ext0_s[1:0], ext_irq_pin_0_i};
        next_st.ext1_s = {st.ext1_s[1:0], ext_irq_pin_1_i};
        next_st.below_s = {st.below_s[1:0], supply_below_i};
        next_st.p6_s1 = port6_pin_i;
        next_st.p6_s2 = st.p6_s1;
        next_st.p6_prev = st.p6_s2;

        // completion alone clears the run bit
        if (events_i.conv_done) begin
            next_st.conv_run = 1'b0;
            next_st.result_high = events_i.conv_result[11:4];
            // low nibble loaded, pin bits kept
            next_st.result_low[3:0] = events_i.conv_result[3:0];
        end

        if (wr & mapped) begin
            unique case (paddr_i)
                OFS_OFFSET_CAL: next_st.offset_cal = wbyte;
                // only the pin-enable nibble is writable
                OFS_RESULT_LOW: next_st.result_low[7:4] = wbyte[7:4];
                OFS_ANALOG_SEL: next_st.analog_sel = wbyte;
                OFS_WAKE_CTRL: begin
                    // wake enables and channel 12-14 enables
                    next_st.wake_ctrl[5:0] = wbyte[5:0];
                    next_st.wake_ctrl[WAKE_FLAG_BIT] =
                        st.wake_ctrl[WAKE_FLAG_BIT] & wbyte[WAKE_FLAG_BIT];
                end
                OFS_IRQ_MASK: next_st.irq_mask = wbyte;
                OFS_DIR5: next_st.dir5 = wbyte;
                OFS_DIR6: next_st.dir6 = wbyte;
                OFS_DIR7: next_st.dir7 = wbyte;
                OFS_DIR8: next_st.dir8 = wbyte[0];
                OFS_TIMER_CTRL: next_st.timer_ctrl = wbyte;
                OFS_CONV_CTRL: begin
                    // software may only set the run bit
                    if (wbyte[CONV_RUN_BIT]) begin
                        next_st.conv_run = 1'b1;
                    end
                    // channel locked while busy or flagged
                    if (!st.irq_flags[IRQ_CONV] && !st.conv_run) begin
                        next_st.conv_chan = wbyte[3:0];
                    end
                end
                OFS_LVD_CTRL: begin
                    next_st.lvd_on = wbyte[LVD_ON_BIT];
                    next_st.lvd_irq_en = wbyte[LVD_IE_BIT];
                end
                default: ;
            endcase
        end

        // a written zero clears a flag, a one leaves it
        if (wr && paddr_i == OFS_IRQ_STATUS) begin
            next_st.irq_flags = st.irq_flags & wbyte;
        end
        // a hardware event beats a clear in the same cycle
        next_st.irq_flags = next_st.irq_flags | ev;

        // set on crossing, held at zero while detector off
        if (lvd_set) begin
            next_st.wake_ctrl[WAKE_FLAG_BIT] = 1'b1;
        end
        if (!st.lvd_on) begin
            next_st.wake_ctrl[WAKE_FLAG_BIT] = 1'b0;
        end
        next_st.wake_ctrl[7] = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '{dir5: DIR_RESET, dir6: DIR_RESET, dir7: DIR_RESET, dir8: 1'b1,
                    ext0_s: PIN_IDLE, ext1_s: PIN_IDLE, offset_cal: REG_RESET,
                    timer_ctrl: REG_RESET, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // Zero-wait slave: every access completes in its first access cycle.
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign prdata_o = rd ? rdata : 32'h0000_0000;

    always_comb begin
        analog_cfg_o.offset_cal_enable = st.offset_cal[CAL_EN_BIT];
        analog_cfg_o.offset_positive = st.offset_cal[CAL_SIGN_BIT];
        analog_cfg_o.offset_lsb = {st.offset_cal[CAL_MAG_LSB +: 3], 1'b0};
        analog_cfg_o.converter_power = st.offset_cal[CAL_PWR_BIT];
        analog_cfg_o.lowvolt_level = st.offset_cal[CAL_LVL_LSB +: 2];
        analog_cfg_o.lowvolt_tenths = lowvolt_tenths(st.offset_cal[CAL_LVL_LSB +: 2]);
        analog_cfg_o.lowvolt_detector_on = st.lvd_on;
        analog_cfg_o.conv_run = st.conv_run;
        analog_cfg_o.conv_channel = st.conv_chan;
        // channel enables gathered from three registers
        analog_cfg_o.analog_en = {st.wake_ctrl[2:0], st.result_low[7:4], st.analog_sel};
        timer_cfg_o.timer_c_on = st.timer_ctrl[TMR_C_ON_BIT];
        timer_cfg_o.timer_b_on = st.timer_ctrl[TMR_B_ON_BIT];
        timer_cfg_o.timer_c_ratio = prescale_ratio(st.timer_ctrl[TMR_C_PRE_LSB +: 3]);
        timer_cfg_o.timer_b_ratio = prescale_ratio(st.timer_ctrl[TMR_B_PRE_LSB +: 3]);
        port_dir_o.p5 = st.dir5;
        port_dir_o.p6 = st.dir6;
        port_dir_o.p7 = st.dir7;
        port_dir_o.p8 = st.dir8;
    end

    // Wake sources need their wake enables; other masked flags only interrupt, but pin-change and conversion interrupts also need their wake enables.
    always_comb begin
        wake_request_o = (st.wake_ctrl[WAKE_FLAG_BIT] & st.wake_ctrl[WAKE_LVD_BIT])
                       | (st.irq_flags[IRQ_PC] & st.wake_ctrl[WAKE_PC_BIT])
                       | (st.irq_flags[IRQ_CONV] & st.wake_ctrl[WAKE_CONV_BIT]);
        irq_request_o = (st.wake_ctrl[WAKE_FLAG_BIT] & st.wake_ctrl[WAKE_LVD_BIT]
                         & st.lvd_irq_en)
                      | (st.irq_flags[IRQ_PC] & st.wake_ctrl[WAKE_PC_BIT] & st.irq_mask[IRQ_PC])
                      | (st.irq_flags[IRQ_CONV] & st.wake_ctrl[WAKE_CONV_BIT]
                         & st.irq_mask[IRQ_CONV])
                      | |(st.irq_flags & st.irq_mask
                          & ~(8'h01 << IRQ_PC) & ~(8'h01 << IRQ_CONV));
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_cal_write;
        wr && paddr_i == OFS_OFFSET_CAL |=> analog_cfg_o.offset_cal_enable == $past(pwdata_i[7])
            && analog_cfg_o.offset_positive == $past(pwdata_i[6])
            && analog_cfg_o.converter_power == $past(pwdata_i[2]);
    endproperty
    a_cal_write: assert property (p_cal_write) else $error("Calibration write not applied.");
    property p_mag_write;
        wr && paddr_i == OFS_OFFSET_CAL |=> analog_cfg_o.offset_lsb == {$past(pwdata_i[5:3]), 1'b0};
    endproperty
    a_mag_write: assert property (p_mag_write) else $error("Offset magnitude wrong.");
    property p_conv_done;
        events_i.conv_done && !(wr && paddr_i == OFS_CONV_CTRL) |=>
            st.result_high == $past(events_i.conv_result[11:4]) && !st.conv_run
            && st.irq_flags[IRQ_CONV];
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("Completion effects missing.");
    property p_low_nibble;
        events_i.conv_done && !(wr && paddr_i == OFS_RESULT_LOW) |=>
            st.result_low[3:0] == $past(events_i.conv_result[3:0])
            && st.result_low[7:4] == $past(st.result_low[7:4]);
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("Low result load wrong.");
    property p_lvd_off;
        !st.lvd_on |=> !st.wake_ctrl[WAKE_FLAG_BIT];
    endproperty
    a_lvd_off: assert property (p_lvd_off) else $error("Flag set with detector off.");
    property p_lvd_rise;
        $rose(st.wake_ctrl[WAKE_FLAG_BIT]) |-> $past(lvd_set);
    endproperty
    a_lvd_rise: assert property (p_lvd_rise) else $error("Low-voltage flag set by write.");
    property p_flag_cause;
        (st.irq_flags & ~$past(st.irq_flags) & ~$past(ev)) == 8'h00;
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("Status flag without event.");
    property p_status_read;
        rd && paddr_i == OFS_IRQ_STATUS |-> prdata_o[7:0] == (st.irq_flags & st.irq_mask)
            && pready_o && !pslverr_o;
    endproperty
    a_status_read: assert property (p_status_read) else $error("Status read not masked.");
    property p_run_fall;
        $fell(st.conv_run) |-> $past(events_i.conv_done);
    endproperty
    a_run_fall: assert property (p_run_fall) else $error("Run bit cleared early.");
    property p_chan_lock;
        $changed(st.conv_chan) |-> $past(!st.conv_run && !st.irq_flags[IRQ_CONV]);
    endproperty
    a_chan_lock: assert property (p_chan_lock) else $error("Channel changed while busy.");
    property p_timer_write;
        wr && paddr_i == OFS_TIMER_CTRL |=> timer_cfg_o.timer_c_on == $past(pwdata_i[7])
            && timer_cfg_o.timer_b_ratio == prescale_ratio($past(pwdata_i[2:0]));
    endproperty
    a_timer_write: assert property (p_timer_write) else $error("Timer control wrong.");
    property p_pc_wake;
        st.irq_flags[IRQ_PC] && !st.wake_ctrl[WAKE_PC_BIT] && !st.irq_flags[IRQ_CONV]
            && !st.wake_ctrl[WAKE_FLAG_BIT] |-> !wake_request_o;
    endproperty
    a_pc_wake: assert property (p_pc_wake) else $error("Pin change woke while disabled.");
    property p_conv_wake;
        st.irq_flags[IRQ_CONV] && !st.wake_ctrl[WAKE_CONV_BIT] && !st.irq_flags[IRQ_PC]
            && !st.wake_ctrl[WAKE_FLAG_BIT] |-> !wake_request_o;
    endproperty
    a_conv_wake: assert property (p_conv_wake) else $error("Conversion wake not gated.");
    property p_lvd_wake;
        st.wake_ctrl[WAKE_FLAG_BIT] && !st.wake_ctrl[WAKE_LVD_BIT] && !st.irq_flags[IRQ_PC]
            && !st.irq_flags[IRQ_CONV] |-> !wake_request_o;
    endproperty
    a_lvd_wake: assert property (p_lvd_wake) else $error("Low-voltage wake not gated.");
    // A hardware event must land even when software clears the status in the same cycle.
    property p_event_set;
        ev != 8'h00 |=> (st.irq_flags & $past(ev)) == $past(ev);
    endproperty
    a_event_set: assert property (p_event_set) else $error("Event did not set flag.");
    property p_flag_clear;
        wr && paddr_i == OFS_IRQ_STATUS |=>
            (st.irq_flags & ~$past(ev) & ~$past(pwdata_i[7:0])) == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Written zero did not clear.");
    property p_level_low;
        analog_cfg_o.lowvolt_level == 2'h3 |-> analog_cfg_o.lowvolt_tenths == 6'h16;
    endproperty
    a_level_low: assert property (p_level_low) else $error("Lowest threshold wrong.");
    property p_prescale_c;
        wr && paddr_i == OFS_TIMER_CTRL && pwdata_i[5:3] == 3'h5 |=>
            timer_cfg_o.timer_c_ratio == 9'h040;
    endproperty
    a_prescale_c: assert property (p_prescale_c) else $error("Prescale decode wrong.");
    property p_dir8_write;
        wr && paddr_i == OFS_DIR8 |=> port_dir_o.p8 == $past(pwdata_i[0]);
    endproperty
    a_dir8_write: assert property (p_dir8_write) else $error("Port eight direction wrong.");
    property p_lvd_enable;
        wr && paddr_i == OFS_LVD_CTRL |=> analog_cfg_o.lowvolt_detector_on == $past(pwdata_i[7]);
    endproperty
    a_lvd_enable: assert property (p_lvd_enable) else $error("Detector enable wrong.");
    property p_sel_write;
        wr && paddr_i == OFS_ANALOG_SEL |=>
            analog_cfg_o.analog_en[7:0] == $past(pwdata_i[7:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("Port six enables wrong.");

    c_conv_done: cover property (st.conv_run ##[1:50] $fell(st.conv_run));
    c_lvd_flag: cover property ($rose(st.wake_ctrl[WAKE_FLAG_BIT]));
    c_status_clear: cover property (st.irq_flags != 8'h00 ##1 st.irq_flags == 8'h00);
    c_pc_wake: cover property (wake_request_o && st.irq_flags[IRQ_PC]);
    c_ext_edge: cover property ($rose(st.irq_flags[IRQ_EXT0]));
endmodule
`default_nettype wire

/* File: tb/awitr_regs_tb.sv */
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module awitr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import awitr_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    awitr_events_t events = '0;
    logic ext0 = 1'b1;
    logic ext1 = 1'b1;
    logic [7:0] port6 = 8'h00;
    logic supply_below = 1'b0;
    awitr_analog_cfg_t acfg;
    awitr_timer_cfg_t tcfg;
    awitr_port_dir_t pdir;
    logic wake;
    logic irq;
    int error_cnt = 0;
    int n_compared = 0;
    logic [7:0] rd_v;
    logic err_v;
    logic [5:0] lvl_tab [4] = '{6'h2d, 6'h28, 6'h21, 6'h16};
    logic [8:0] pre_tab [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h040, 9'h080, 9'h100};

    always #2.5 sys_clk = ~sys_clk;

    awitr_regs uut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .events_i(events),
        .ext_irq_pin_0_i(ext0), .ext_irq_pin_1_i(ext1), .port6_pin_i(port6),
        .supply_below_i(supply_below), .analog_cfg_o(acfg), .timer_cfg_o(tcfg),
        .port_dir_o(pdir), .wake_request_o(wake), .irq_request_o(irq));

    task automatic finish_test();
        $display("Compared %0d values, %0d mismatches", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Read data is taken at the edge where pready is seen, then the request drops.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            finish_test();
        end
        rd_v = prdata[7:0];
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One more edge lets the register update settle before the caller looks.
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd_v, e)
    endtask

    task automatic ev(input awitr_events_t v);
        @(posedge sys_clk);
        events <= v;
        @(posedge sys_clk);
        events <= '0;
        @(posedge sys_clk);
    endtask

    task automatic wait_sync();
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic t_reset_dir();
        `CHK(pdir, 25'h1ffffff)
        rdc(OFS_DIR5, 8'hff);
        rdc(OFS_DIR8, 8'h01);
        rdc(OFS_TIMER_CTRL, 8'h00);
        wr(OFS_DIR6, 8'h5a);
        rdc(OFS_DIR6, 8'h5a);
        wr(OFS_DIR8, 8'h00);
        `CHK(pdir.p6, 8'h5a)
        `CHK(pdir.p8, 1'b0)
        $display("reset and direction done");
    endtask

    task automatic t_offset();
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            wr(OFS_OFFSET_CAL, {1'b1, m[0], m, m[1], m[1:0]});
            `CHK(acfg.offset_cal_enable, 1'b1)
            `CHK(acfg.offset_positive, m[0])
            `CHK(acfg.offset_lsb, {m, 1'b0})
            `CHK(acfg.converter_power, m[1])
            `CHK(acfg.lowvolt_tenths, lvl_tab[m[1:0]])
            `CHK(acfg.lowvolt_level, m[1:0])
        end
        rdc(OFS_OFFSET_CAL, 8'hff);
        wr(OFS_OFFSET_CAL, 8'h00);
        `CHK(acfg.offset_cal_enable, 1'b0)
        $display("offset calibration done");
    endtask

    task automatic t_timer();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(OFS_TIMER_CTRL, {c[0], c[1], c, ~c});
            `CHK(tcfg.timer_c_on, c[0])
            `CHK(tcfg.timer_b_on, c[1])
            `CHK(tcfg.timer_c_ratio, pre_tab[c])
            `CHK(tcfg.timer_b_ratio, pre_tab[~c])
        end
        $display("timer control done");
    endtask

    task automatic t_conv();
        wr(OFS_IRQ_MASK, 8'hff);
        wr(OFS_RESULT_LOW, 8'hf3);
        rdc(OFS_RESULT_LOW, 8'hf0);
        wr(OFS_ANALOG_SEL, 8'h81);
        wr(OFS_WAKE_CTRL, 8'h0d);
        `CHK(acfg.analog_en, {3'h5, 4'hf, 8'h81})
        wr(OFS_CONV_CTRL, 8'h15);
        wr(OFS_CONV_CTRL, 8'h09);
        `CHK(acfg.conv_run, 1'b1)
        `CHK(acfg.conv_channel, 4'h5)
        ev({1'b1, 12'habc, 4'h0});
        `CHK(acfg.conv_run, 1'b0)
        `CHK(wake, 1'b1)
        rdc(OFS_RESULT_HIGH, 8'hab);
        rdc(OFS_RESULT_LOW, 8'hfc);
        rdc(OFS_IRQ_STATUS, 8'h08);
        wr(OFS_RESULT_HIGH, 8'h00);
        rdc(OFS_RESULT_HIGH, 8'hab);
        wr(OFS_CONV_CTRL, 8'h03);
        `CHK(acfg.conv_channel, 4'h5)
        wr(OFS_IRQ_STATUS, 8'hff);
        rdc(OFS_IRQ_STATUS, 8'h08);
        wr(OFS_IRQ_STATUS, 8'hf7);
        rdc(OFS_IRQ_STATUS, 8'h00);
        `CHK(wake, 1'b0)
        wr(OFS_CONV_CTRL, 8'h03);
        `CHK(acfg.conv_channel, 4'h3)
        wr(OFS_WAKE_CTRL, 8'h05);
        ev({1'b1, 12'h123, 4'h0});
        `CHK(wake, 1'b0)
        wr(OFS_IRQ_STATUS, 8'h00);
        $display("conversion done");
    endtask

    task automatic t_events();
        wr(OFS_IRQ_STATUS, 8'hff);
        rdc(OFS_IRQ_STATUS, 8'h00);
        ev({1'b0, 12'h0, 4'hf});
        wr(OFS_IRQ_MASK, 8'h55);
        rdc(OFS_IRQ_STATUS, 8'h51);
        wr(OFS_IRQ_MASK, 8'hff);
        rdc(OFS_IRQ_STATUS, 8'h71);
        ext0 <= 1'b0;
        wait_sync();
        ext1 <= 1'b0;
        port6 <= 8'h10;
        wait_sync();
        rdc(OFS_IRQ_STATUS, 8'hf7);
        `CHK(irq, 1'b1)
        wr(OFS_IRQ_MASK, 8'h00);
        `CHK(irq, 1'b0)
        wr(OFS_WAKE_CTRL, 8'h10);
        `CHK(wake, 1'b1)
        wr(OFS_WAKE_CTRL, 8'h00);
        `CHK(wake, 1'b0)
        wr(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_IRQ_MASK, 8'hff);
        rdc(OFS_IRQ_STATUS, 8'h00);
        ext0 <= 1'b1;
        ext1 <= 1'b1;
        $display("status events done");
    endtask

    task automatic t_lvd();
        wr(OFS_LVD_CTRL, 8'h40);
        supply_below <= 1'b1;
        wait_sync();
        wr(OFS_LVD_CTRL, 8'hc0);
        `CHK(acfg.lowvolt_detector_on, 1'b1)
        rdc(OFS_WAKE_CTRL, 8'h00);
        supply_below <= 1'b0;
        wait_sync();
        supply_below <= 1'b1;
        wait_sync();
        rdc(OFS_WAKE_CTRL, 8'h40);
        wr(OFS_WAKE_CTRL, 8'h60);
        `CHK(wake, 1'b1)
        wr(OFS_WAKE_CTRL, 8'h20);
        `CHK(wake, 1'b0)
        wr(OFS_WAKE_CTRL, 8'h60);
        rdc(OFS_WAKE_CTRL, 8'h20);
        supply_below <= 1'b0;
        wait_sync();
        supply_below <= 1'b1;
        wait_sync();
        wr(OFS_LVD_CTRL, 8'h40);
        `CHK(acfg.lowvolt_detector_on, 1'b0)
        rdc(OFS_WAKE_CTRL, 8'h20);
        apb(1'b0, 8'h3c, 8'h00);
        `CHK({err_v, rd_v}, 9'h100)
        $display("low voltage and unmapped done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_reset_dir();
        t_offset();
        t_timer();
        t_conv();
        t_events();
        t_lvd();
        finish_test();
    end
endmodule
`default_nettype wire
